/* ucb_uart_ctrl.sv */
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1 - tx disabled: abort, reset transmitter, float TX
// RQ2 - drive TX only when tx and uart enabled
// RQ3 - rx disabled: abort, reset receiver, float RX
// RQ4 - receiver owns RX only when both enabled
// RQ5 - bit rate clock over 64 or 16 times N+1
// RQ6 - free running 8-bit counter times bit periods
// RQ7 - divisor is 8-bit read/write value N
// RQ8 - address word when top data bit set
// RQ9 - address words raise receive interrupt when enabled
// RQ10 - non-address words discarded, no interrupt
// RQ11 - RX falling edge wakes when clock stopped
// RQ12 - no wake while clock runs or disabled
// RQ13 - rx enable gates overrun and full interrupts
// RQ14 - idle enable gates transmitter idle interrupt
// RQ15 - empty enable gates transmitter empty interrupt
// RQ16 - uart off clears enables, flags; sets idles
// RQ17 - uart off resets baud counter only
// RQ18 - interrupt is OR of enabled sources
// RQ19 - reload on terminal count, scaled bit tick
module ucb_uart_ctrl
  import ucb_pkg::*;
#(
  parameter int DIV_W = 8,
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              tx_serial_i,
  input  wire logic              tx_idle_i,
  input  wire logic              tx_empty_i,
  input  wire logic              rx_idle_i,
  input  wire logic              rx_word_valid_i,
  input  wire logic [8:0]        rx_word_i,
  input  wire logic              rx_pin_i,
  input  wire logic              uart_clk_on_i,
  output logic                   tx_pin_o,
  output logic                   tx_pin_oe_n,
  output logic                   rx_serial_o,
  output logic                   tx_run_o,
  output logic                   rx_run_o,
  output logic                   word_len_sel_o,
  output logic                   break_ctl_o,
  output logic                   baud_sample_tick_o,
  output logic                   baud_bit_tick_o,
  output logic                   irq_o
);
  import ucb_pkg::*;

  // ==========================================================
  // elaboration checks
  if (DIV_W != 8) begin : g_bad_div
    $error("ucb_uart_ctrl: DIV_W must be 8");
  end
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
    $error("ucb_uart_ctrl: ADDR_W must be 5 to 8");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic              w_lane0;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [7:0]        ctrl2;
    logic [DIV_W-1:0]  divisor;
    logic [CFG_W-1:0]  cfg;
    logic [IRQ_W-1:0]  irq_en;
    logic [IRQ_W-1:0]  irq_sts;
    logic              rx_full;
    logic              overrun;
    logic [8:0]        rx_data;
    logic [DIV_W-1:0]  div_cnt;
    logic [5:0]        pre_cnt;
    logic              sample_tick;
    logic              bit_tick;
    logic              rx_s1;
    logic              rx_s2;
    logic              rx_s3;
    logic              clk_s1;
    logic              clk_s2;
    logic              tx_idle_flag_p;
    logic              tempty_p;
    logic              tx_pin;
    logic              tx_oe_n;
    logic              rx_serial;
    logic              tx_run;
    logic              rx_run;
    logic              irq;
  } ucb_state_s;

  ucb_state_s q;
  ucb_state_s d;

  // ==========================================================
  // address decode, shared by read and write paths
  function automatic logic [3:0] ucb_decode(input logic [ADDR_W-1:0] a);
    logic [7:0] ab;
    ab = 8'(a);
    ucb_decode = 4'h8;
    if (ab[1:0] == 2'h0 && ab < 8'(NUM_REGS * 4)) begin
      ucb_decode = 4'(ab[7:2]);
    end
  endfunction

  localparam logic [3:0] IX_CTRL2   = 4'(OFS_CTRL2 >> 2);
  localparam logic [3:0] IX_DIVISOR = 4'(OFS_DIVISOR >> 2);
  localparam logic [3:0] IX_CONFIG  = 4'(OFS_CONFIG >> 2);
  localparam logic [3:0] IX_FLAGS   = 4'(OFS_FLAGS >> 2);
  localparam logic [3:0] IX_RXDATA  = 4'(OFS_RXDATA >> 2);
  localparam logic [3:0] IX_IRQ_STS = 4'(OFS_IRQ_STS >> 2);
  localparam logic [3:0] IX_IRQ_CLR = 4'(OFS_IRQ_CLR >> 2);
  localparam logic [3:0] IX_IRQ_EN  = 4'(OFS_IRQ_EN >> 2);

  // ==========================================================
  // next state
  always_comb begin
    logic             on;
    logic             tx_en;
    logic             rx_en;
    logic             do_wr;
    logic [3:0]       wix;
    logic [3:0]       rix;
    logic [IRQ_W-1:0] clr;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] gate;
    logic             rd_clr;
    logic             addr_bit;
    logic             keep;
    logic             tx_idle_flag_f;
    logic             tempty_f;
    logic             rx_idle_f;
    logic [5:0]       pre_top;
    d         = q;
    on        = q.cfg[CFG_ON];
    tx_en     = on & q.ctrl2[C2_TX_ENABLE_BIT];
    rx_en     = on & q.ctrl2[C2_RX_ENABLE_BIT];
    do_wr     = 1'b0;
    wix       = 4'h8;
    rix       = 4'h8;
    clr       = '0;
    ev        = '0;
    gate      = '0;
    rd_clr    = 1'b0;
    addr_bit  = 1'b0;
    keep      = 1'b0;
    pre_top   = PRE_TOP_LOW;
    tx_idle_flag_f   = ~tx_en | tx_idle_i;   // [RQ16]
    tempty_f  = ~tx_en | tx_empty_i;  // [RQ16]
    rx_idle_f = ~rx_en | rx_idle_i;   // [RQ16]

    // ==========================================================
    // pin synchronisers
    d.rx_s1  = rx_pin_i;
    d.rx_s2  = q.rx_s1;
    d.rx_s3  = q.rx_s2;
    d.clk_s1 = uart_clk_on_i;
    d.clk_s2 = q.clk_s1;

    // ==========================================================
    // write channel, address and data in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got   = 1'b1;
      d.w_data  = s_axi_wdata;
      d.w_lane0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      do_wr    = 1'b1;
      wix      = ucb_decode(q.aw_addr);
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = (wix[3] || wix == IX_FLAGS || wix == IX_RXDATA || wix == IX_IRQ_STS) ?
                 RESP_SLVERR : RESP_OKAY;
    end
    if (do_wr && q.w_lane0) begin
      case (wix)
        IX_CTRL2:   d.ctrl2   = q.w_data[7:0];
        IX_DIVISOR: d.divisor = q.w_data[DIV_W-1:0];  // [RQ7]
        IX_CONFIG:  d.cfg     = q.w_data[CFG_W-1:0];
        IX_IRQ_CLR: clr       = q.w_data[IRQ_W-1:0];
        IX_IRQ_EN:  d.irq_en  = q.w_data[IRQ_W-1:0];
        default:    d.cfg     = d.cfg;
      endcase
    end

    // ==========================================================
    // read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      rix      = ucb_decode(s_axi_araddr);
      d.rvalid = 1'b1;
      d.rresp  = (rix[3] || rix == IX_IRQ_CLR) ? RESP_SLVERR : RESP_OKAY;
      d.rdata  = '0;
      case (rix)
        IX_CTRL2:   d.rdata[7:0]       = q.ctrl2;
        IX_DIVISOR: d.rdata[DIV_W-1:0] = q.divisor;
        IX_CONFIG:  d.rdata[CFG_W-1:0] = q.cfg;
        IX_FLAGS:   d.rdata[4:0]       = {rx_idle_f, tx_idle_flag_f, tempty_f, q.overrun, q.rx_full};
        IX_RXDATA: begin
          d.rdata[8:0] = q.rx_data;
          rd_clr       = 1'b1;
        end
        IX_IRQ_STS: d.rdata[IRQ_W-1:0] = q.irq_sts;
        IX_IRQ_EN:  d.rdata[IRQ_W-1:0] = q.irq_en;
        default:    d.rdata            = '0;
      endcase
    end

    // ==========================================================
    // baud generator
    pre_top       = q.ctrl2[C2_BAUD_SPEED_SEL] ? PRE_TOP_HIGH : PRE_TOP_LOW;  // [RQ5]
    d.sample_tick = 1'b0;
    d.bit_tick    = 1'b0;
    if (!on) begin
      d.div_cnt = DIV_RST;  // [RQ17]
      d.pre_cnt = '0;       // [RQ17]
    end else if (q.div_cnt == '0) begin
      d.div_cnt     = q.divisor;  // [RQ6] [RQ19]
      d.sample_tick = 1'b1;
      if (q.pre_cnt >= pre_top) begin
        d.pre_cnt  = '0;
        d.bit_tick = 1'b1;  // [RQ5] [RQ19]
      end else begin
        d.pre_cnt = q.pre_cnt + 6'h01;
      end
    end else begin
      d.div_cnt = q.div_cnt - DIV_W'(1);  // [RQ6]
    end

    // ==========================================================
    // receive word acceptance; reading data clears, a new word wins
    if (rd_clr) begin
      d.rx_full = 1'b0;
      d.overrun = 1'b0;
    end
    addr_bit = q.cfg[CFG_WLS] ? rx_word_i[8] : rx_word_i[7];  // [RQ8]
    keep     = ~q.ctrl2[C2_ADDR] | addr_bit;                   // [RQ10]
    if (rx_word_valid_i && rx_en && keep) begin
      ev[IRQ_ADDR] = q.ctrl2[C2_ADDR];  // [RQ9]
      if (q.rx_full && !rd_clr) begin
        // held word is kept; newcomer is lost
        d.overrun    = 1'b1;
        ev[IRQ_OVR]  = ~q.overrun;
      end else begin
        d.rx_data    = rx_word_i;
        d.rx_full    = 1'b1;
        ev[IRQ_RX]   = 1'b1;
      end
    end

    // ==========================================================
    // transmitter flags and wake-up
    d.tx_idle_flag_p      = tx_idle_flag_f;
    d.tempty_p     = tempty_f;
    ev[IRQ_TIDL]   = tx_idle_flag_f & ~q.tx_idle_flag_p;    // [RQ14]
    ev[IRQ_TEMP]   = tempty_f & ~q.tempty_p;  // [RQ15]
    // stopped-clock status is synchronised; wake only then
    ev[IRQ_WAKE]   = q.rx_s3 & ~q.rx_s2 & q.ctrl2[C2_WAKE] & ~q.clk_s2;  // [RQ11] [RQ12]

    // ==========================================================
    // uart off forces state
    if (!d.cfg[CFG_ON]) begin
      d.ctrl2[C2_TX_ENABLE_BIT] = 1'b0;  // [RQ16]
      d.ctrl2[C2_RX_ENABLE_BIT] = 1'b0;  // [RQ16]
      d.cfg[CFG_BRK]   = 1'b0;  // [RQ16]
      d.rx_full        = 1'b0;  // [RQ16]
      d.overrun        = 1'b0;  // [RQ16]
    end

    // ==========================================================
    // interrupt: set wins over clear
    d.irq_sts       = (q.irq_sts & ~clr) | ev;
    gate[IRQ_RX]    = d.ctrl2[C2_RIE];   // [RQ13]
    gate[IRQ_OVR]   = d.ctrl2[C2_RIE];   // [RQ13]
    gate[IRQ_TIDL]  = d.ctrl2[C2_TX_IDLE_IRQ_EN];  // [RQ14]
    gate[IRQ_TEMP]  = d.ctrl2[C2_TX_EMPTY_IRQ_EN];  // [RQ15]
    gate[IRQ_ADDR]  = d.ctrl2[C2_RIE];   // [RQ9]
    gate[IRQ_WAKE]  = 1'b1;              // [RQ11]
    d.irq           = |(d.irq_sts & d.irq_en & gate);  // [RQ18]

    // ==========================================================
    // pins and engine controls
    d.tx_run    = d.cfg[CFG_ON] & d.ctrl2[C2_TX_ENABLE_BIT];  // [RQ1]
    d.rx_run    = d.cfg[CFG_ON] & d.ctrl2[C2_RX_ENABLE_BIT];  // [RQ3]
    d.tx_oe_n   = ~d.tx_run;                          // [RQ1] [RQ2]
    d.tx_pin    = d.tx_run ? (tx_serial_i & ~d.cfg[CFG_BRK]) : 1'b1;  // [RQ2]
    d.rx_serial = d.rx_run ? q.rx_s2 : 1'b1;          // [RQ3] [RQ4]

    // ==========================================================
    // channel readiness
    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready  = ~d.w_got & ~d.bvalid;
    d.arready = ~d.rvalid;
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.ctrl2    <= CTRL2_RST;
      q.cfg      <= CFG_RST;
      q.divisor  <= DIV_RST;
      q.div_cnt  <= DIV_RST;
      q.rx_s1    <= 1'b1;
      q.rx_s2    <= 1'b1;
      q.rx_s3    <= 1'b1;
      q.tx_idle_flag_p  <= 1'b1;
      q.tempty_p <= 1'b1;
      q.tx_pin   <= 1'b1;
      q.tx_oe_n  <= 1'b1;
      q.rx_serial <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready      = q.awready;
  assign s_axi_wready       = q.wready;
  assign s_axi_bresp        = q.bresp;
  assign s_axi_bvalid       = q.bvalid;
  assign s_axi_arready      = q.arready;
  assign s_axi_rdata        = q.rdata;
  assign s_axi_rresp        = q.rresp;
  assign s_axi_rvalid       = q.rvalid;
  assign tx_pin_o           = q.tx_pin;
  assign tx_pin_oe_n        = q.tx_oe_n;
  assign rx_serial_o        = q.rx_serial;
  assign tx_run_o           = q.tx_run;
  assign rx_run_o           = q.rx_run;
  assign word_len_sel_o     = q.cfg[CFG_WLS];
  assign break_ctl_o        = q.cfg[CFG_BRK];
  assign baud_sample_tick_o = q.sample_tick;
  assign baud_bit_tick_o    = q.bit_tick;
  assign irq_o              = q.irq;

endmodule : ucb_uart_ctrl
`default_nettype wire

/* ucb_pkg.sv */
`default_nettype none
package ucb_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL2   = 8'h00;
  localparam logic [7:0] OFS_DIVISOR = 8'h04;
  localparam logic [7:0] OFS_CONFIG  = 8'h08;
  localparam logic [7:0] OFS_FLAGS   = 8'h0c;
  localparam logic [7:0] OFS_RXDATA  = 8'h10;
  localparam logic [7:0] OFS_IRQ_STS = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h1c;
  localparam int         NUM_REGS    = 8;

  // ==========================================================
  // uart_control_two fields
  localparam int C2_TX_ENABLE_BIT = 7;
  localparam int C2_RX_ENABLE_BIT = 6;
  localparam int C2_BAUD_SPEED_SEL = 5;
  localparam int C2_ADDR = 4;
  localparam int C2_WAKE = 3;
  localparam int C2_RIE  = 2;
  localparam int C2_TX_IDLE_IRQ_EN = 1;
  localparam int C2_TX_EMPTY_IRQ_EN = 0;
  localparam logic [7:0] CTRL2_RST = 8'h00;

  // ==========================================================
  // config register fields
  localparam int CFG_ON  = 0;
  localparam int CFG_WLS = 1;
  localparam int CFG_BRK = 2;
  localparam int CFG_W   = 3;
  localparam logic [2:0] CFG_RST = 3'h0;

  // ==========================================================
  // interrupt status layout
  localparam int IRQ_RX   = 0;
  localparam int IRQ_OVR  = 1;
  localparam int IRQ_TIDL = 2;
  localparam int IRQ_TEMP = 3;
  localparam int IRQ_ADDR = 4;
  localparam int IRQ_WAKE = 5;
  localparam int IRQ_W    = 6;

  // ==========================================================
  // baud generator
  localparam logic [5:0] PRE_TOP_LOW  = 6'h3f;  // divide by 64
  localparam logic [5:0] PRE_TOP_HIGH = 6'h0f;  // divide by 16
  localparam logic [7:0] DIV_RST      = 8'h00;  // value undefined, zero chosen

  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ucb_pkg
`default_nettype wire

/* ucb_uart_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker
module ucb_uart_ctrl_chk #(
  parameter int DIV_W  = 8,
  parameter int ADDR_W = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_serial_i,
  input wire logic        rx_pin_i,
  input wire logic        tx_pin_o,
  input wire logic        tx_pin_oe_n,
  input wire logic        rx_serial_o,
  input wire logic        tx_run_o,
  input wire logic        rx_run_o,
  input wire logic        break_ctl_o,
  input wire logic        baud_bit_tick_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // one settled cycle allowed, enables and pin drive are separate flops
  a_tx_float: assert property (!tx_run_o && !$past(tx_run_o) |-> tx_pin_oe_n && tx_pin_o)
    else $error("tx pin not floating");
  a_tx_owns: assert property (tx_run_o && $past(tx_run_o) |-> !tx_pin_oe_n)
    else $error("tx pin not driven");
  a_tx_follow: assert property (
    tx_run_o && $past(tx_run_o) && !break_ctl_o && !$past(break_ctl_o)
    |-> tx_pin_o == $past(tx_serial_i))
    else $error("tx pin does not follow");
  a_rx_float: assert property (!rx_run_o && !$past(rx_run_o) |-> rx_serial_o)
    else $error("receiver sees pin while off");
  a_rx_delay: assert property (rx_run_o [*4] |-> rx_serial_o == $past(rx_pin_i, 3))
    else $error("rx path delay wrong");
  a_tick_single: assert property (baud_bit_tick_o |=> !baud_bit_tick_o)
    else $error("bit tick too wide");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  c_tick: cover property (baud_bit_tick_o);
  c_irq: cover property ($rose(irq_o));
  c_tx_on: cover property ($rose(tx_run_o));
endmodule // ucb_uart_ctrl_chk

bind ucb_uart_ctrl ucb_uart_ctrl_chk #(.DIV_W(DIV_W), .ADDR_W(ADDR_W)) chk_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tx_serial_i, .rx_pin_i, .tx_pin_o,
  .tx_pin_oe_n, .rx_serial_o, .tx_run_o, .rx_run_o, .break_ctl_o, .baud_bit_tick_o, .irq_o);
`default_nettype wire

/* ucb_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// remote serial peer, drives rx line only
module ucb_peer (
  input  wire logic aclk,
  output logic      rx_pin
);
  initial rx_pin = 1'b1; // line idles at mark
  // called just after a rising edge of aclk
  task automatic set_rx(input logic v);
    rx_pin <= v;
  endtask
endmodule // ucb_peer
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench
module tb_top;
  import ucb_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, tx_serial_i, tx_idle_i, tx_empty_i, rx_idle_i, rx_pin_i;
  logic        rx_word_valid_i, uart_clk_on_i, tx_pin_o, tx_pin_oe_n, rx_serial_o;
  logic        tx_run_o, rx_run_o, break_ctl_o, baud_sample_tick_o, baud_bit_tick_o, irq_o;
  logic        word_len_sel_o;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [8:0]  rx_word_i;
  int          bad_count = 0, tests_run = 0, cyc = 0;

  ucb_uart_ctrl #(.DIV_W(8), .ADDR_W(8)) ucb_uart_ctrl_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_serial_i, .tx_idle_i, .tx_empty_i, .rx_idle_i,
    .rx_word_valid_i, .rx_word_i, .rx_pin_i, .uart_clk_on_i, .tx_pin_o, .tx_pin_oe_n,
    .rx_serial_o, .tx_run_o, .rx_run_o, .word_len_sel_o, .break_ctl_o,
    .baud_sample_tick_o, .baud_bit_tick_o, .irq_o);
  ucb_peer ucb_peer_inst (.aclk, .rx_pin(rx_pin_i));

  // ==========================================
  // helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // bready and rready stay high, so the answer is taken where seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
  endtask
  task automatic word(input logic [8:0] w);
    rx_word_i <= w;
    rx_word_valid_i <= 1'b1;
    @(posedge aclk);
    rx_word_valid_i <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic clr;
    rd(OFS_RXDATA);
    wr(OFS_IRQ_CLR, 32'h3f);
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!baud_bit_tick_o);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs;
    rd(OFS_CTRL2);
    chk("ctrl2 reset", 32'h0, d);
    wr(OFS_DIVISOR, 32'ha5);
    rd(OFS_DIVISOR);
    chk("divisor", 32'ha5, d);
    wr(OFS_CTRL2, 32'hff);
    rd(OFS_CTRL2);
    chk("ctrl2 while off", 32'h3f, d);
    wr(8'h20, 32'h1);
    chk("unmapped resp", RESP_SLVERR, r);
    wr(OFS_IRQ_STS, 32'h1);
    chk("read-only resp", RESP_SLVERR, r);
    $display("test regs done");
  endtask
  task automatic t_pins;
    wr(OFS_CONFIG, 32'h1);
    wr(OFS_CTRL2, 32'hc0);
    tx_serial_i <= 1'b0;
    ucb_peer_inst.set_rx(1'b0);
    repeat (5) @(posedge aclk);
    chk("tx run", 1, tx_run_o);
    chk("tx oe_n on", 0, tx_pin_oe_n);
    chk("tx pin low", 0, tx_pin_o);
    chk("rx serial low", 0, rx_serial_o);
    wr(OFS_CTRL2, 32'h80);
    repeat (2) @(posedge aclk);
    chk("rx run off", 0, rx_run_o);
    chk("rx float", 1, rx_serial_o);
    wr(OFS_CTRL2, 32'h00);
    repeat (2) @(posedge aclk);
    chk("tx oe_n off", 1, tx_pin_oe_n);
    ucb_peer_inst.set_rx(1'b1);
    tx_serial_i <= 1'b1;
    wr(OFS_CTRL2, 32'hc0);
    wr(OFS_CONFIG, 32'h0);
    wr(OFS_CONFIG, 32'h1);
    rd(OFS_CTRL2);
    chk("enables cleared", 32'h0, d);
    rd(OFS_DIVISOR);
    chk("divisor kept", 32'ha5, d);
    $display("test pins done");
  endtask
  task automatic t_flags;
    wr(OFS_CTRL2, 32'h40);
    rx_idle_i <= 1'b1;
    word(9'h001);
    rd(OFS_FLAGS);
    chk("flags full", 32'h1d, d);
    rx_idle_i <= 1'b0;
    word(9'h002);
    rd(OFS_FLAGS);
    chk("flags overrun", 32'h0f, d);
    wr(OFS_CONFIG, 32'h0);
    rd(OFS_FLAGS);
    chk("flags off", 32'h1c, d);
    wr(OFS_CONFIG, 32'h1);
    wr(OFS_CTRL2, 32'h80);
    wr(OFS_CONFIG, 32'h5);
    repeat (2) @(posedge aclk);
    chk("break flag", 1, break_ctl_o);
    chk("break pin", 0, tx_pin_o);
    wr(OFS_CONFIG, 32'h1);
    s_axi_wstrb <= 4'he;
    wr(OFS_DIVISOR, 32'h11);
    s_axi_wstrb <= 4'hf;
    rd(OFS_DIVISOR);
    chk("strobe ignored", 32'ha5, d);
    clr;
    $display("test flags done");
  endtask
  task automatic t_baud;
    int n;
    int nv[4] = '{2, 2, 255, 0};
    for (int k = 0; k < 4; k++) begin
      wr(OFS_DIVISOR, 32'(nv[k]));
      wr(OFS_CTRL2, (k == 0) ? 32'h0 : 32'h20);
      gap(n);
      gap(n);
      chk("bit period", ((k == 0) ? 64 : 16) * (nv[k] + 1), n);
      chk("sample tick", 1, baud_sample_tick_o);
    end
    $display("test baud done");
  endtask
  task automatic t_irq;
    wr(OFS_IRQ_EN, 32'h3f);
    wr(OFS_CTRL2, 32'h44);
    word(9'h055);
    chk("rx irq", 1, irq_o);
    rd(OFS_RXDATA);
    chk("rx data", 32'h55, d);
    wr(OFS_IRQ_CLR, 32'h3f);
    rd(OFS_IRQ_STS);
    chk("status cleared", 32'h0, d);
    wr(OFS_CTRL2, 32'h40);
    word(9'h055);
    chk("rx irq masked", 0, irq_o);
    clr;
    wr(OFS_CTRL2, 32'h54);
    word(9'h07f);
    chk("data word irq", 0, irq_o);
    rd(OFS_IRQ_STS);
    chk("data word status", 32'h0, d);
    word(9'h080);
    chk("addr irq", 1, irq_o);
    rd(OFS_IRQ_STS);
    chk("addr status", 32'h10, d & 32'h10);
    clr;
    wr(OFS_CONFIG, 32'h3);
    chk("word len sel", 1, word_len_sel_o);
    word(9'h080);
    chk("9-bit data irq", 0, irq_o);
    word(9'h100);
    chk("9-bit addr irq", 1, irq_o);
    clr;
    wr(OFS_CONFIG, 32'h1);
    $display("test irq done");
  endtask
  task automatic t_tx;
    for (int i = 0; i < 2; i++) begin
      for (int e = 1; e >= 0; e--) begin
        wr(OFS_CTRL2, 32'h80 | 32'(e << (1 - i)));
        if (i == 0) tx_idle_i <= 1'b0; else tx_empty_i <= 1'b0;
        repeat (2) @(posedge aclk);
        clr;
        if (i == 0) tx_idle_i <= 1'b1; else tx_empty_i <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("tx event irq", 32'(e), irq_o);
      end
    end
    $display("test tx done");
  endtask
  task automatic t_wake;
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CTRL2, (k < 2) ? 32'h08 : 32'h00);
      uart_clk_on_i <= (k == 1);
      repeat (4) @(posedge aclk);
      clr;
      ucb_peer_inst.set_rx(1'b0);
      repeat (8) @(posedge aclk);
      chk("wake irq", 32'(k == 0), irq_o);
      rd(OFS_IRQ_STS);
      chk("wake status", (k == 0) ? 32'h20 : 32'h0, d & 32'h20);
      ucb_peer_inst.set_rx(1'b1);
    end
    uart_clk_on_i <= 1'b1;
    $display("test wake done");
  endtask

  // ==========================================
  // run
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ceiling well above the slow divisor case
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      final_report;
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tx_idle_i} = '0;
    {tx_empty_i, rx_idle_i, rx_word_valid_i} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_word_i} = '0;
    {s_axi_bready, s_axi_rready, tx_serial_i, uart_clk_on_i} = '1;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs;
    t_pins;
    t_flags;
    t_baud;
    t_irq;
    t_tx;
    t_wake;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
